/* hdl/lcd_shared_gpio_ports.sv */
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "seg_port_defs.svh"
// ****************************************
// two lcd-shared general purpose ports
// ****************************************
module lcd_shared_gpio_ports (
   input wire logic clk,
   input wire logic nrst,
   input wire seg_port_pkg::bus_req_t bus,
   output logic [7:0] rdata,
   input wire logic [1:0][7:0] pin_in,
   input wire logic [1:0][7:0] lcd_seg,
   output seg_port_pkg::pin_drive_t [1:0] pin_drive
);

   // ****************************************
   // reset release synchroniser
   // ****************************************
   logic rst_meta_n; // first stage, read only by second
   logic rst_sync_n; // reset used by the block

   // two flops release the reset on the clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // ****************************************
   // address decode
   // ****************************************
   // kind of register at an address
   function automatic seg_port_pkg::reg_kind_t kind_of(
      input logic [3:0] a
   );
      case (a)
         `SEG_PORT_A_LATCH_OFS,
         `SEG_PORT_B_LATCH_OFS: kind_of = seg_port_pkg::REG_LATCH;
         `SEG_PORT_A_DIR_OFS,
         `SEG_PORT_B_DIR_OFS: kind_of = seg_port_pkg::REG_DIR;
         `SEG_PORT_A_LCD_SEL_OFS,
         `SEG_PORT_B_LCD_SEL_OFS: kind_of = seg_port_pkg::REG_LCD_SEL;
         `SEG_BIT_SET_OFS: kind_of = seg_port_pkg::REG_BIT_SET;
         `SEG_BIT_CLR_OFS: kind_of = seg_port_pkg::REG_BIT_CLR;
         default: kind_of = seg_port_pkg::REG_NONE;
      endcase
   endfunction

   // port index addressed by a register offset
   function automatic logic port_of(input logic [3:0] a);
      port_of = (a >= `SEG_PORT_B_LATCH_OFS);
   endfunction

   // ****************************************
   // state
   // ****************************************
   seg_port_pkg::gpio_state_t state; // registered state
   seg_port_pkg::gpio_state_t next_state; // next state
   logic [1:0][7:0] readback; // per-port data read value

   // ****************************************
   // per-port pin logic
   // ****************************************
   genvar p;
   generate
      for (p = 0; p < `SEG_PORT_COUNT; p++) begin : g_port
         // both ports use the same cell, each its own registers
         seg_port_pins u_pins (
            .regs(state.port[p]),
            .pin_in(pin_in[p]),
            .lcd_seg(lcd_seg[p]),
            .drive(pin_drive[p]),
            .readback(readback[p])
         );
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   seg_port_pkg::reg_kind_t kind; // decoded kind
   logic sel; // addressed port
   logic op_port; // port of a bit operation
   logic [2:0] op_bit; // bit of a bit operation
   logic [7:0] merged; // read-modify-write result

   always_comb begin
      next_state = state;
      kind = kind_of(bus.addr);
      sel = port_of(bus.addr);
      op_port = bus.wdata[`SEG_BITOP_PORT_POS];
      op_bit = bus.wdata[`SEG_BITOP_INDEX_MSB:`SEG_BITOP_INDEX_LSB];
      merged = readback[op_port];
      // bit ops start from what a data read returns
      merged[op_bit] = (kind == seg_port_pkg::REG_BIT_SET);
      if (bus.wr) begin
         case (kind)
            // full write reaches every latch bit
            seg_port_pkg::REG_LATCH: begin
               next_state.port[sel].latch = bus.wdata;
            end
            seg_port_pkg::REG_DIR: begin
               next_state.port[sel].dir = bus.wdata;
            end
            seg_port_pkg::REG_LCD_SEL: begin
               next_state.port[sel].lcd_sel = bus.wdata;
            end
            // input bits take the pin level into the latch
            seg_port_pkg::REG_BIT_SET,
            seg_port_pkg::REG_BIT_CLR: begin
               next_state.port[op_port].latch = merged;
            end
            default: begin
               // unmapped write is ignored
            end
         endcase
      end
      // read data valid for one cycle only
      next_state.rdata = `SEG_RDATA_RESET;
      if (bus.rd) begin
         case (kind)
            seg_port_pkg::REG_LATCH: begin
               next_state.rdata = readback[sel];
            end
            seg_port_pkg::REG_DIR: begin
               next_state.rdata = state.port[sel].dir;
            end
            seg_port_pkg::REG_LCD_SEL: begin
               next_state.rdata = state.port[sel].lcd_sel;
            end
            default: begin
               // command and unmapped offsets read zero
               next_state.rdata = `SEG_RDATA_RESET;
            end
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (int i = 0; i < `SEG_PORT_COUNT; i++) begin
            state.port[i].latch <= `SEG_LATCH_RESET;
            state.port[i].dir <= `SEG_DIR_RESET;
            state.port[i].lcd_sel <= `SEG_LCD_SEL_RESET;
         end
         state.rdata <= `SEG_RDATA_RESET;
      end else begin
         state <= next_state;
      end
   end

   // read data from the register
   assign rdata = state.rdata;

endmodule
`default_nettype wire

/* hdl/seg_port_defs.svh */
// What this block does
// - eight pins, each direction set independently
// - second port mirrors the first exactly
// - both bits zero makes pin input
// - direction one, select zero drives latch
// - select one routes LCD segment out
// - reset clears latch, direction, select
// - input bits read back pin level
// - select-only bits read back zero
// - direction-one bits read back latch
// - bit operations write input levels back
`ifndef SEG_PORT_DEFS_SVH
`define SEG_PORT_DEFS_SVH

// ****************************************
// widths and counts
// ****************************************
`define SEG_PORT_WIDTH 8
`define SEG_PORT_COUNT 2
`define SEG_ADDR_WIDTH 4

// ****************************************
// register offsets
// ****************************************
`define SEG_PORT_A_LATCH_OFS 4'h0
`define SEG_PORT_A_DIR_OFS 4'h1
`define SEG_PORT_A_LCD_SEL_OFS 4'h2
`define SEG_PORT_B_LATCH_OFS 4'h3
`define SEG_PORT_B_DIR_OFS 4'h4
`define SEG_PORT_B_LCD_SEL_OFS 4'h5
`define SEG_BIT_SET_OFS 4'h6
`define SEG_BIT_CLR_OFS 4'h7

// ****************************************
// bit operation command fields
// ****************************************
`define SEG_BITOP_INDEX_MSB 2
`define SEG_BITOP_INDEX_LSB 0
`define SEG_BITOP_PORT_POS 3

// ****************************************
// reset values
// ****************************************
`define SEG_LATCH_RESET 8'h00
`define SEG_DIR_RESET 8'h00
`define SEG_LCD_SEL_RESET 8'h00
`define SEG_RDATA_RESET 8'h00

`endif

/* hdl/seg_port_pins.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pin mux and read-back of one port
// ****************************************
module seg_port_pins (
   input wire seg_port_pkg::port_regs_t regs,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] lcd_seg,
   output seg_port_pkg::pin_drive_t drive,
   output logic [7:0] readback
);

   // per-bit drive and read-back
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (regs.lcd_sel[i]) begin
            // segment waveform wins over latch and direction
            drive.out[i] = lcd_seg[i];
            drive.oe[i] = 1'b1;
         end else if (regs.dir[i]) begin
            // plain output from the latch
            drive.out[i] = regs.latch[i];
            drive.oe[i] = 1'b1;
         end else begin
            // input: pin released, latch ignored
            drive.out[i] = 1'b0;
            drive.oe[i] = 1'b0;
         end
         if (regs.dir[i]) begin
            readback[i] = regs.latch[i];
         end else if (regs.lcd_sel[i]) begin
            readback[i] = 1'b0;
         end else begin
            readback[i] = pin_in[i];
         end
      end
   end

endmodule
`default_nettype wire

/* hdl/seg_port_pkg.sv */
package seg_port_pkg;

   // ****************************************
   // register set of one port
   // ****************************************
   typedef struct packed {
      logic [7:0] latch;   // output latch
      logic [7:0] dir;     // 1 = output
      logic [7:0] lcd_sel; // 1 = lcd segment
   } port_regs_t;

   // ****************************************
   // drive towards one port's pins
   // ****************************************
   typedef struct packed {
      logic [7:0] out; // level driven
      logic [7:0] oe;  // high while driving
   } pin_drive_t;

   // ****************************************
   // register bus request
   // ****************************************
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // ****************************************
   // whole state of the top module
   // ****************************************
   typedef struct packed {
      port_regs_t [1:0] port; // index 0 = port a, 1 = port b
      logic [7:0] rdata;      // registered read data
   } gpio_state_t;

   // ****************************************
   // kind of register addressed
   // ****************************************
   typedef enum logic [2:0] {
      REG_LATCH = 3'b000,
      REG_DIR = 3'b001,
      REG_LCD_SEL = 3'b010,
      REG_BIT_SET = 3'b011,
      REG_BIT_CLR = 3'b100,
      REG_NONE = 3'b111
   } reg_kind_t;

endpackage

/* sim/gpio_ports_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// shadow registers and port checks
// ****
module gpio_ports_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire seg_port_pkg::bus_req_t bus,
   input wire logic [7:0] rdata,
   input wire logic [1:0][7:0] pin_in,
   input wire logic [1:0][7:0] lcd_seg,
   input wire seg_port_pkg::pin_drive_t [1:0] pin_drive
);
   logic [1:0][7:0] lat, dir, sel; // shadow registers
   logic [7:0] bop, rd_exp; // bit command result, expected read
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // data read value of one port
   function automatic logic [7:0] rv(input logic p);
      return (dir[p] & lat[p]) | (~dir[p] & ~sel[p] & pin_in[p]);
   endfunction
   // read-modify-write of a bit command
   always_comb begin
      bop = rv(bus.wdata[3]);
      bop[bus.wdata[2:0]] = ~bus.addr[0];
   end
   // shadow follows writes; expected read captured each cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lat <= '0;
         dir <= '0;
         sel <= '0;
         rd_exp <= 8'h00;
      end else begin
         if (bus.wr) begin
            case (bus.addr)
               4'h0: lat[0] <= bus.wdata;
               4'h1: dir[0] <= bus.wdata;
               4'h2: sel[0] <= bus.wdata;
               4'h3: lat[1] <= bus.wdata;
               4'h4: dir[1] <= bus.wdata;
               4'h5: sel[1] <= bus.wdata;
               4'h6, 4'h7: lat[bus.wdata[3]] <= bop;
               default: ;
            endcase
         end
         case (bus.addr)
            4'h0: rd_exp <= rv(1'b0);
            4'h1: rd_exp <= dir[0];
            4'h2: rd_exp <= sel[0];
            4'h3: rd_exp <= rv(1'b1);
            4'h4: rd_exp <= dir[1];
            4'h5: rd_exp <= sel[1];
            default: rd_exp <= 8'h00;
         endcase
      end
   end
   a_oe_port_a: assert property (pin_drive[0].oe == (dir[0] | sel[0]))
      else $error("port a enable wrong");
   a_oe_port_b: assert property (pin_drive[1].oe == (dir[1] | sel[1]))
      else $error("port b enable wrong");
   a_out_port_a: assert property (((pin_drive[0].out ^ ((sel[0] & lcd_seg[0])
      | (~sel[0] & lat[0]))) & pin_drive[0].oe) == 8'h00)
      else $error("port a level wrong");
   a_out_port_b: assert property (((pin_drive[1].out ^ ((sel[1] & lcd_seg[1])
      | (~sel[1] & lat[1]))) & pin_drive[1].oe) == 8'h00)
      else $error("port b level wrong");
   a_read_value: assert property ($past(bus.rd) |-> rdata == rd_exp)
      else $error("read data wrong");
   a_read_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("read data not cleared");
   a_reset_clear: assert property ($rose(nrst) |-> (pin_drive[0].oe
      | pin_drive[1].oe | rdata) == 8'h00)
      else $error("state not cleared by reset");
   a_latch_write: assert property ((bus.wr && bus.addr == 4'h0) |=>
      ((pin_drive[0].out ^ $past(bus.wdata)) & pin_drive[0].oe & ~sel[0])
      == 8'h00) else $error("latch write lost");
endmodule
bind lcd_shared_gpio_ports gpio_ports_chk u_chk (.clk(clk), .nrst(nrst),
   .bus(bus), .rdata(rdata), .pin_in(pin_in), .lcd_seg(lcd_seg),
   .pin_drive(pin_drive));
`default_nettype wire

/* sim/lcd_shared_gpio_ports_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// register-level tests of both ports
// ****
module lcd_shared_gpio_ports_tb;
   logic clk, nrst;
   seg_port_pkg::bus_req_t bus;
   logic [7:0] rdata;
   logic [1:0][7:0] pin_in, lcd_seg, ext;
   seg_port_pkg::pin_drive_t [1:0] pin_drive;
   int mismatches, n_tests;
   lcd_shared_gpio_ports u_dut (.clk(clk), .nrst(nrst), .bus(bus),
      .rdata(rdata), .pin_in(pin_in), .lcd_seg(lcd_seg),
      .pin_drive(pin_drive));
   seg_port_far_side u_far (.clk(clk), .ext(ext), .pin_drive(pin_drive),
      .pin_in(pin_in), .lcd_seg(lcd_seg));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      n_tests++;
      if (got !== want) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   // one bus cycle, then idle
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] want);
      acc(1'b0, a, 8'h00);
      #1 chk(rdata, want);
   endtask
   task automatic reset_dut;
      nrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic results;
      $display("mismatches %0d of %0d compares", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      results();
   end
   initial begin
      bus = '0;
      nrst = 1'b0;
      ext = {8'h96, 8'ha5};
      mismatches = 0;
      n_tests = 0;
      reset_dut();
      for (int i = 0; i < 2; i++) begin
         rdc(4'(3 * i), ext[i]);
         rdc(4'(3 * i + 1), 8'h00);
         rdc(4'(3 * i + 2), 8'h00);
      end
      chk(pin_drive[0].oe | pin_drive[1].oe, 8'h00);
      acc(1'b1, 4'h0, 8'h5a);
      rdc(4'h0, 8'ha5);
      acc(1'b1, 4'h1, 8'hf0);
      rdc(4'h0, 8'h55);
      chk(pin_drive[0].out & pin_drive[0].oe, 8'h50);
      acc(1'b1, 4'h2, 8'h3c);
      rdc(4'h0, 8'h51);
      chk(pin_drive[0].oe, 8'hfc);
      chk(pin_drive[0].out & 8'h3c, lcd_seg[0] & 8'h3c);
      acc(1'b1, 4'h7, 8'h04);
      acc(1'b1, 4'h2, 8'h00);
      acc(1'b1, 4'h1, 8'hff);
      rdc(4'h0, 8'h41);
      acc(1'b1, 4'h6, 8'h08);
      acc(1'b1, 4'h4, 8'hff);
      rdc(4'h3, 8'h97);
      chk(pin_drive[1].out, 8'h97);
      acc(1'b1, 4'h5, 8'hff);
      rdc(4'h3, 8'h97);
      acc(1'b1, 4'hf, 8'hff);
      rdc(4'hf, 8'h00);
      rdc(4'h0, 8'h41);
      reset_dut();
      rdc(4'h0, ext[0]);
      rdc(4'h4, 8'h00);
      results();
   end
endmodule
`default_nettype wire

/* sim/seg_port_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// pins and segment driver outside the ports
// ****
module seg_port_far_side (
   input wire logic clk,
   input wire logic [1:0][7:0] ext,
   input wire seg_port_pkg::pin_drive_t [1:0] pin_drive,
   output logic [1:0][7:0] pin_in,
   output logic [1:0][7:0] lcd_seg
);
   // driven pins show the port level, others the outside level
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         pin_in[p] = (pin_drive[p].oe & pin_drive[p].out)
            | (~pin_drive[p].oe & ext[p]);
      end
   end
   // segment waveform changes every cycle; seeded once at time zero,
   // so a plain always is used (an always_ff may not share its target)
   initial lcd_seg = {8'h0f, 8'hc3};
   always @(posedge clk) begin
      lcd_seg <= {lcd_seg[1] + 8'h3b, lcd_seg[0] + 8'h71};
   end
endmodule
`default_nettype wire
